// ---- hw/rhpl_pkg.sv ----
package rhpl_pkg;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 8;
   localparam int CLK_MHZ = 100;
   // lockout delay window after power-fail goes low, in microseconds
   localparam int LOCK_MIN_US = 30;
   localparam int LOCK_MAX_US = 63;
   localparam int LOCK_MIN_CYC = LOCK_MIN_US * CLK_MHZ;
   localparam int LOCK_MAX_CYC = LOCK_MAX_US * CLK_MHZ;
   // wide enough for a programmed delay of 255 us at the core clock
   localparam int LOCK_W = 15;
   // register select locations (main status common to both pages)
   localparam logic [4:0] ADR_MAIN_STATUS = 5'h00;
   localparam logic [4:0] ADR_INT_STATUS = 5'h01;
   localparam logic [4:0] ADR_RT_MODE = 5'h02;
   localparam logic [4:0] ADR_INT_CTRL0 = 5'h03;
   localparam logic [4:0] ADR_INT_CTRL1 = 5'h04;
   localparam logic [4:0] ADR_LOCK_CTRL = 5'h05;
   // main status fields
   localparam int MS_PERIODIC = 0;
   localparam int MS_ALARM = 1;
   localparam int MS_POWER_FAIL_IN_N = 2;
   localparam int N_FLAGS = 3;
   localparam int MS_PAGE = 6;
   localparam int MS_BLOCK = 7;
   // real-time mode fields
   localparam int RT_XSEL_LO = 0;
   localparam int RT_SINGLE = 2;
   localparam int RT_XSEL_VALID = 3;
   // interrupt control 1 and 0 fields
   localparam int IC1_PF_ENABLE = 7;
   localparam int IC1_PF_MASK = 6;
   localparam int IC1_MFO_INT = 0;
   localparam int IC0_PER_MASK = 0;
   localparam int IC0_ALM_MASK = 1;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [LOCK_W-1:0] LOCK_ZERO = 15'h0000;
   typedef enum logic [1:0] {
      RHPL_IDLE = 2'b00,
      RHPL_READ = 2'b01,
      RHPL_WRITE = 2'b10
   } rhpl_state_t;
endpackage

// ---- hw/rhpl_host_port.sv ----
// Overview of operation
// - chip select, read and write strobes are active low; select plus strobe accesses.
// - after power failure lockout, strobes are ignored; an access under way completes.
// - five-bit register select picks the location on each access.
// - register select is ignored while power failure lockout holds.
// - read runs while select and read strobe are low; ends when either rises.
// - write runs while select and write strobe are low; ends when either rises.
// - oscillator runs only with main supply ok and the crystal-select valid bit set.
// - multi-function output is a second interrupt or the oscillator signal.
// - multi-function output push-pull active high; open-drain in standby.
// - interrupt request asserts on an enabled timing or power-fail event.
// - interrupt request is active low open-drain held level until cleared.
// - writing one to a main status flag bit (bits 0 to 2) clears it; zero leaves it.
// - power-fail low with no write in progress floats the data bus.
// - lockout follows power-fail low after 30 to 63 us unless delay programmed.
// - periodic, alarm and power-fail sources each have a mask and status.
// - interrupt control 1 bit seven enables power-fail lockout and status; bus float does not need it.
// - main status bits choose page and control block; main status on both pages.
`timescale 1ns/1ps
`default_nettype none
module rhpl_host_port
   import rhpl_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // host strobes and select
   input wire logic chipSelectN,
   input wire logic readStrobeN,
   input wire logic writeStrobeN,
   input wire logic [ADDR_W-1:0] registerSelect,
   // host data bus, split
   input wire logic [DATA_W-1:0] hostDataIn,
   output logic [DATA_W-1:0] hostDataOut,
   output logic hostDataOe,
   // power and events
   input wire logic powerFailInN,
   input wire logic mainSupplyOk,
   input wire logic batteryAboveMain,
   input wire logic periodicEvent,
   input wire logic alarmEvent,
   input wire logic crystalInput,
   // outputs
   output logic crystalOutput,
   output logic oscRunning,
   output logic hostLockedOut,
   output logic interruptRequestOut,
   output logic interruptRequestOe,
   output logic multiFunctionOutValue,
   output logic multiFunctionOutOe
);
   rhpl_state_t state_q, state_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [DATA_W-1:0] wdata_q, wdata_d;
   logic [DATA_W-1:0] rdata_q, rdata_d;
   logic [DATA_W-1:0] mainStatus_q, mainStatus_d;
   logic [DATA_W-1:0] rtMode_q, rtMode_d;
   logic [DATA_W-1:0] intCtrl0_q, intCtrl0_d;
   logic [DATA_W-1:0] intCtrl1_q, intCtrl1_d;
   logic [DATA_W-1:0] lockCtrl_q, lockCtrl_d;
   logic [DATA_W-1:0] ram_q [0:63];
   logic [LOCK_W-1:0] lockCnt_q, lockCnt_d;
   logic locked_q, locked_d;
   logic pfPrev_q, pfPrev_d;
   logic pfEvent;
   logic readReq, writeReq, writeEnd;
   logic [5:0] ramIdx;
   logic [LOCK_W-1:0] lockTarget;
   logic pfEnabled;
   logic irqLevel;
   logic [N_FLAGS-1:0] flagSet, flagClr, flagNext;

   assign pfEnabled = intCtrl1_q[IC1_PF_ENABLE];
   // strobes are both-low qualified; lockout gates only new accesses
   assign readReq = !chipSelectN && !readStrobeN && !locked_q;
   assign writeReq = !chipSelectN && !writeStrobeN && !locked_q;
   assign writeEnd = (state_q == RHPL_WRITE) && (chipSelectN || writeStrobeN);
   // page bit extends the select into scratch locations
   assign ramIdx = {mainStatus_q[MS_PAGE], addr_q};
   // programmed delay counts in microseconds when nonzero
   assign lockTarget = (lockCtrl_q == RESET_BYTE) ? LOCK_W'(LOCK_MIN_CYC)
                     : LOCK_W'(int'(lockCtrl_q) * CLK_MHZ);

   always_comb begin
      state_d = state_q;
      addr_d = addr_q;
      wdata_d = wdata_q;
      case (state_q)
         RHPL_IDLE: begin
            if (readReq) begin
               state_d = RHPL_READ;
               addr_d = registerSelect;
            end else if (writeReq) begin
               state_d = RHPL_WRITE;
               addr_d = registerSelect;
            end
         end
         RHPL_READ: begin
            if (chipSelectN || readStrobeN) begin
               state_d = RHPL_IDLE;
            end
         end
         RHPL_WRITE: begin
            wdata_d = hostDataIn;
            if (writeEnd) begin
               state_d = RHPL_IDLE;
            end
         end
         default: state_d = RHPL_IDLE;
      endcase
   end

   // read data mux
   always_comb begin
      rdata_d = rdata_q;
      if (state_q == RHPL_IDLE && readReq) begin
         if (registerSelect == ADR_MAIN_STATUS) begin
            rdata_d = mainStatus_q;
         end else if (!mainStatus_q[MS_BLOCK] && registerSelect == ADR_RT_MODE) begin
            rdata_d = rtMode_q;
         end else if (mainStatus_q[MS_BLOCK] && registerSelect == ADR_INT_CTRL0) begin
            rdata_d = intCtrl0_q;
         end else if (mainStatus_q[MS_BLOCK] && registerSelect == ADR_INT_CTRL1) begin
            rdata_d = intCtrl1_q;
         end else if (mainStatus_q[MS_BLOCK] && registerSelect == ADR_LOCK_CTRL) begin
            rdata_d = lockCtrl_q;
         end else begin
            rdata_d = ram_q[{mainStatus_q[MS_PAGE], registerSelect}];
         end
      end
   end

   // power-fail lockout timer
   always_comb begin
      pfPrev_d = powerFailInN;
      lockCnt_d = lockCnt_q;
      locked_d = locked_q;
      if (!pfEnabled || powerFailInN) begin
         lockCnt_d = LOCK_ZERO;
         locked_d = 1'b0;
      end else if (!locked_q) begin
         if (lockCnt_q >= lockTarget) begin
            locked_d = 1'b1;
         end else begin
            lockCnt_d = lockCnt_q + LOCK_W'(1);
         end
      end
   end
   assign pfEvent = pfEnabled && pfPrev_q && !powerFailInN;

   // status flags share one shape: clear on a written one, set by the event
   assign flagSet = {pfEvent, alarmEvent, periodicEvent};
   assign flagClr = (writeEnd && addr_q == ADR_MAIN_STATUS) ? wdata_q[MS_POWER_FAIL_IN_N:MS_PERIODIC]
                  : {N_FLAGS{1'b0}};
   genvar gi;
   for (gi = 0; gi < N_FLAGS; gi++) begin : g_flag
      // set is ored in last so an event in the clear cycle is never lost
      assign flagNext[gi] = flagSet[gi] | (mainStatus_q[MS_PERIODIC + gi] & ~flagClr[gi]);
   end

   // configuration and status registers
   always_comb begin
      mainStatus_d = mainStatus_q;
      rtMode_d = rtMode_q;
      intCtrl0_d = intCtrl0_q;
      intCtrl1_d = intCtrl1_q;
      lockCtrl_d = lockCtrl_q;
      if (writeEnd) begin
         if (addr_q == ADR_MAIN_STATUS) begin
            // page and block bits are plain storage
            mainStatus_d[MS_PAGE] = wdata_q[MS_PAGE];
            mainStatus_d[MS_BLOCK] = wdata_q[MS_BLOCK];
         end else if (!mainStatus_q[MS_BLOCK] && addr_q == ADR_RT_MODE) begin
            rtMode_d = wdata_q;
         end else if (mainStatus_q[MS_BLOCK] && addr_q == ADR_INT_CTRL0) begin
            intCtrl0_d = wdata_q;
         end else if (mainStatus_q[MS_BLOCK] && addr_q == ADR_INT_CTRL1) begin
            intCtrl1_d = wdata_q;
         end else if (mainStatus_q[MS_BLOCK] && addr_q == ADR_LOCK_CTRL) begin
            lockCtrl_d = wdata_q;
         end
      end
      mainStatus_d[MS_POWER_FAIL_IN_N:MS_PERIODIC] = flagNext;
   end

   // access sequencer registers
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_q <= RHPL_IDLE;
         addr_q <= '0;
         wdata_q <= RESET_BYTE;
      end else begin
         state_q <= state_d;
         addr_q <= addr_d;
         wdata_q <= wdata_d;
      end
   end

   // read data register
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rdata_q <= RESET_BYTE;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // lockout timer registers; previous pin level resets high, its idle level,
   // so release of reset never looks like a falling edge
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         lockCnt_q <= LOCK_ZERO;
         locked_q <= 1'b0;
         pfPrev_q <= 1'b1;
      end else begin
         lockCnt_q <= lockCnt_d;
         locked_q <= locked_d;
         pfPrev_q <= pfPrev_d;
      end
   end

   // configuration and status registers
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         mainStatus_q <= RESET_BYTE;
         rtMode_q <= RESET_BYTE;
         intCtrl0_q <= RESET_BYTE;
         intCtrl1_q <= RESET_BYTE;
         lockCtrl_q <= RESET_BYTE;
      end else begin
         mainStatus_q <= mainStatus_d;
         rtMode_q <= rtMode_d;
         intCtrl0_q <= intCtrl0_d;
         intCtrl1_q <= intCtrl1_d;
         lockCtrl_q <= lockCtrl_d;
      end
   end

   // scratch ram takes data at write end; no reset, contents random at power-on
   always_ff @(posedge clock) begin
      if (writeEnd && addr_q != ADR_MAIN_STATUS) begin
         ram_q[ramIdx] <= wdata_q;
      end
   end

   assign hostDataOut = rdata_q;
   // bus floats when power fails unless a write holds it; device only drives on reads
   assign hostDataOe = (state_q == RHPL_READ) && !chipSelectN && !readStrobeN
                       && powerFailInN;

   assign oscRunning = mainSupplyOk && rtMode_q[RT_XSEL_VALID];
   assign crystalOutput = oscRunning ? ~crystalInput : 1'b0;
   assign hostLockedOut = locked_q;

   assign irqLevel = (mainStatus_q[MS_PERIODIC] && intCtrl0_q[IC0_PER_MASK])
                  || (mainStatus_q[MS_ALARM] && intCtrl0_q[IC0_ALM_MASK])
                  || (mainStatus_q[MS_POWER_FAIL_IN_N] && intCtrl1_q[IC1_PF_MASK]);
   // open drain: only ever pulls low, held until status cleared
   assign interruptRequestOut = 1'b0;
   assign interruptRequestOe = irqLevel;

   always_comb begin
      multiFunctionOutValue = intCtrl1_q[IC1_MFO_INT] ? irqLevel
                              : (oscRunning && crystalInput);
      // standby: drive low only, release for high
      if (batteryAboveMain) begin
         multiFunctionOutOe = !multiFunctionOutValue;
      end else begin
         multiFunctionOutOe = 1'b1;
      end
   end
endmodule // rhpl_host_port
`default_nettype wire

// ---- dv/rhpl_host_port_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module rhpl_host_port_checker (
   // watched ports
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic chipSelectN,
   input wire logic readStrobeN,
   input wire logic powerFailInN,
   input wire logic batteryAboveMain,
   input wire logic crystalInput,
   input wire logic crystalOutput,
   input wire logic oscRunning,
   input wire logic hostDataOe,
   input wire logic hostLockedOut,
   input wire logic interruptRequestOut,
   input wire logic interruptRequestOe,
   input wire logic multiFunctionOutValue,
   input wire logic multiFunctionOutOe
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   property p_irqLow; interruptRequestOut == 1'b0; endproperty
   a_irqLow: assert property (p_irqLow) else $error("irq pin not low when driven");
   property p_readOe; hostDataOe |-> $past(!chipSelectN && !readStrobeN); endproperty
   a_readOe: assert property (p_readOe) else $error("bus driven outside a read");
   property p_pfFloat; (!powerFailInN && !$past(powerFailInN)) |-> !hostDataOe; endproperty
   a_pfFloat: assert property (p_pfFloat) else $error("bus driven in power fail");
   property p_mfoDrive;
      batteryAboveMain ? (multiFunctionOutOe == !multiFunctionOutValue) : multiFunctionOutOe;
   endproperty
   a_mfoDrive: assert property (p_mfoDrive) else $error("mfo drive mode wrong");
   property p_oscOut; oscRunning |-> (crystalOutput == !crystalInput); endproperty
   a_oscOut: assert property (p_oscOut) else $error("crystal output not inverted");
   property p_lockCause; $rose(hostLockedOut) |-> !powerFailInN; endproperty
   a_lockCause: assert property (p_lockCause) else $error("lockout without power fail");
   // only a completed write may drop a held request
   property p_irqHeld;
      (interruptRequestOe && chipSelectN && $past(chipSelectN) && $past(chipSelectN, 2))
         |=> interruptRequestOe;
   endproperty
   a_irqHeld: assert property (p_irqHeld) else $error("irq dropped without write");
   property p_lockNoRead;
      (hostLockedOut && $past(hostLockedOut) && !hostDataOe) |=> !hostDataOe;
   endproperty
   a_lockNoRead: assert property (p_lockNoRead) else $error("read started in lockout");
endmodule // rhpl_host_port_checker
bind rhpl_host_port rhpl_host_port_checker i_rhpl_host_port_checker (.*);
`default_nettype wire

// ---- dv/rhpl_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module rhpl_host_model (
   // clock and read side
   input wire logic clock,
   input wire logic [7:0] hostDataOut,
   // strobes and write side
   output logic chipSelectN,
   output logic readStrobeN,
   output logic writeStrobeN,
   output logic [4:0] registerSelect,
   output logic [7:0] hostDataIn
);
   initial begin
      {chipSelectN, readStrobeN, writeStrobeN} = 3'h7;
      registerSelect = 5'h00;
      hostDataIn = 8'h00;
   end
   task automatic wrBegin(input logic [4:0] a, input logic [7:0] d);
      @(negedge clock);
      registerSelect <= a;
      hostDataIn <= d;
      {chipSelectN, writeStrobeN} <= 2'b00;
   endtask
   task automatic wrEnd();
      @(negedge clock);
      {chipSelectN, writeStrobeN} <= 2'b11;
      @(negedge clock);
      // released bus shows the inverse, not a stale value
      hostDataIn <= ~hostDataIn;
      registerSelect <= ~registerSelect;
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      wrBegin(a, d);
      repeat (2) @(negedge clock);
      wrEnd();
   endtask
   task automatic rd(input logic [4:0] a, output logic [7:0] d);
      @(negedge clock);
      registerSelect <= a;
      {chipSelectN, readStrobeN} <= 2'b00;
      repeat (3) @(posedge clock);
      #1 d = hostDataOut;
      @(negedge clock);
      {chipSelectN, readStrobeN} <= 2'b11;
      @(negedge clock);
   endtask
endmodule // rhpl_host_model
`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import rhpl_pkg::*;
   logic clock, sys_rst, csN, rdN, wrN, pfN, supOk, batHi, perEv, almEv, xin;
   logic [4:0] sel;
   logic [7:0] din, dout, rv;
   logic doe, xout, osc, lock, irq, irqOe, multi_function_out, mfoOe;
   int mismatches = 0, n_tests = 0, cyc = 0;
   rhpl_host_model i_rhpl_host_model (.clock(clock), .hostDataOut(dout), .chipSelectN(csN),
      .readStrobeN(rdN), .writeStrobeN(wrN), .registerSelect(sel), .hostDataIn(din));
   rhpl_host_port i_rhpl_host_port (.clock(clock), .sys_rst(sys_rst), .chipSelectN(csN),
      .readStrobeN(rdN), .writeStrobeN(wrN), .registerSelect(sel), .hostDataIn(din),
      .hostDataOut(dout), .hostDataOe(doe), .powerFailInN(pfN), .mainSupplyOk(supOk),
      .batteryAboveMain(batHi), .periodicEvent(perEv), .alarmEvent(almEv), .crystalInput(xin),
      .crystalOutput(xout), .oscRunning(osc), .hostLockedOut(lock), .interruptRequestOut(irq),
      .interruptRequestOe(irqOe), .multiFunctionOutValue(multi_function_out), .multiFunctionOutOe(mfoOe));
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(negedge clock) xin <= ~xin;
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic doReset();
      sys_rst = 1'b1;
      repeat (16) @(negedge clock);
      sys_rst = 1'b0;
   endtask
   task automatic pulse(ref logic ev);
      @(negedge clock) ev = 1'b1;
      @(negedge clock) ev = 1'b0;
      repeat (3) @(negedge clock);
   endtask
   // a hang costs far more than the ~3200 cycles the sequence needs
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         stop_test();
      end
   end
   initial begin
      {pfN, supOk, batHi, perEv, almEv, xin} = 6'b110000;
      doReset();
      check(irqOe, 1'b0);
      check(lock, 1'b0);
      check(osc, 1'b0);
      i_rhpl_host_model.wr(5'h10, 8'ha5);
      i_rhpl_host_model.wr(5'h13, 8'h11);
      i_rhpl_host_model.rd(5'h10, rv);
      check(rv, 8'ha5);
      i_rhpl_host_model.rd(5'h13, rv);
      check(rv, 8'h11);
      i_rhpl_host_model.wr(ADR_RT_MODE, 8'h08);
      check(osc, 1'b1);
      supOk = 1'b0;
      repeat (2) @(negedge clock);
      check(osc, 1'b0);
      supOk = 1'b1;
      i_rhpl_host_model.wr(ADR_MAIN_STATUS, 8'h80);
      i_rhpl_host_model.wr(ADR_INT_CTRL0, 8'h01);
      i_rhpl_host_model.wr(ADR_INT_CTRL1, 8'h01);
      pulse(almEv);
      check(irqOe, 1'b0);
      pulse(perEv);
      check(irqOe, 1'b1);
      check(multi_function_out, 1'b1);
      batHi = 1'b1;
      #1 check(mfoOe, 1'b0);
      batHi = 1'b0;
      i_rhpl_host_model.wr(ADR_MAIN_STATUS, 8'h80);
      check(irqOe, 1'b1);
      i_rhpl_host_model.rd(ADR_MAIN_STATUS, rv);
      check(rv, 8'h83);
      i_rhpl_host_model.wr(ADR_MAIN_STATUS, 8'h81);
      check(irqOe, 1'b0);
      i_rhpl_host_model.wr(ADR_INT_CTRL1, 8'hc0);
      pfN = 1'b0;
      i_rhpl_host_model.wrBegin(5'h12, 8'h3c);
      repeat (2980) @(negedge clock);
      check(lock, 1'b0);
      repeat (100) @(negedge clock);
      check(lock, 1'b1);
      check(irqOe, 1'b1);
      i_rhpl_host_model.wrEnd();
      i_rhpl_host_model.wr(5'h13, 8'hc3);
      pfN = 1'b1;
      doReset();
      i_rhpl_host_model.rd(5'h12, rv);
      check(rv, 8'h3c);
      i_rhpl_host_model.rd(5'h13, rv);
      check(rv, 8'h11);
      stop_test();
   end
endmodule // tb_top
`default_nettype wire
